// ==== pkg/mtc_defs.svh ====
// register offsets, field positions, reset values and counts of the timer/counter
`ifndef MTC_DEFS_SVH
`define MTC_DEFS_SVH
`define MTC_ADDR_W 8
`define MTC_OFS_CTRL_A 8'h00
`define MTC_OFS_CTRL_B 8'h04
`define MTC_OFS_COMPARE 8'h08
`define MTC_OFS_GATE_SET 8'h0C
`define MTC_OFS_STATUS 8'h10
`define MTC_CA_RUN 1:0
`define MTC_CA_MODE 3:2
`define MTC_CA_CLKSEL 6:4
`define MTC_CA_CLEAR 7
`define MTC_CA_LOWSPEED 8
`define MTC_CA_DIVSTAGE 9
`define MTC_CB_EDGE 0
`define MTC_CB_GSRC 2:1
`define MTC_CB_GEDGE 3
`define MTC_CB_GCLK 5:4
`define MTC_CB_PDIS 6
`define MTC_ST_OVF 0
`define MTC_ST_GATE 1
`define MTC_GS_HIGH 7:4
`define MTC_GS_LOW 3:0
`define MTC_CNT_MSB 17
`define MTC_CMP_HI_LSB 11
`define MTC_CNT_MAX 18'h3FFFF
`define MTC_CNT_ZERO 18'h00000
`define MTC_CMP_RST 18'h3FFFF
`define MTC_GS_RST 8'h00
`define MTC_GCNT_LAST 4'hF
`define MTC_RUN_STOP 2'h0
`define MTC_HDIV_W 23
`define MTC_FDIV_W 15
`endif

// ==== pkg/mtc_pkg.sv ====
// types shared by the multimode timer/counter
package mtc_pkg;
  typedef enum logic [1:0] {
    MTC_TIMER = 2'b00,
    MTC_EVENT = 2'b01,
    MTC_PULSE = 2'b10,
    MTC_FREQ  = 2'b11
  } mtc_mode_e;
  typedef enum logic [2:0] {
    MTC_C23 = 3'b000,
    MTC_C13 = 3'b001,
    MTC_C11 = 3'b010,
    MTC_C7  = 3'b011,
    MTC_C3  = 3'b100,
    MTC_CFC = 3'b101,
    MTC_CFS = 3'b110,
    MTC_CEXT = 3'b111
  } mtc_clk_e;
  typedef enum logic [1:0] {
    MTC_G_PIN  = 2'b00,
    MTC_G_INT  = 2'b01,
    MTC_G_PART = 2'b10,
    MTC_G_RSV  = 2'b11
  } mtc_gsrc_e;
  typedef struct packed {
    logic [1:0] run;
    mtc_mode_e mode;
    mtc_clk_e clksel;
    logic low_speed;
    logic div_stage;
    logic edge_both;
    mtc_gsrc_e gsrc;
    logic gedge;
    logic [1:0] gclk;
    logic pdis;
    logic [17:0] cmp;
    logic [7:0] gset;
    logic [17:0] cnt;
    logic ovf;
    logic [22:0] hdiv;
    logic [14:0] fdiv;
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic g_on;
    logic g_act;
    logic [3:0] g_cnt;
    logic [3:0] g_ta;
    logic [3:0] g_tb;
    logic gate_d;
    logic irq;
    logic pin;
    logic [31:0] rdata;
  } mtc_state_s;
endpackage

// ==== src/mtc_top.sv ====
// multimode 18-bit up counter: timer, event, pulse width and frequency measurement
`timescale 1ns/1ps
`include "mtc_defs.svh"

module mtc_top (
  input wire logic clk_i, // 10 MHz system clock
  input wire logic nrst_i, // asynchronous reset, active low
  input wire logic [7:0] addr_i, // register byte address
  input wire logic [31:0] wdata_i, // register write data
  input wire logic we_i, // write strobe
  input wire logic re_i, // read strobe
  output logic [31:0] rdata_o, // read data, cycle after read strobe
  input wire logic external_count_input_i, // count or window pin
  input wire logic external_gate_input_i, // external gate pin
  input wire logic partner_timer_output_i, // partner timer output
  input wire logic low_freq_clock_i, // low frequency clock pin
  output logic counter_one_irq_o, // interrupt pulse
  output logic partner_pin_o // partner output to its pin
);

  mtc_pkg::mtc_state_s r;
  mtc_pkg::mtc_state_s n;
  logic fs_edge;
  logic fs_src;
  logic itick;
  logic gtick;
  logic e;
  logic e_fall;
  logic e_rise;
  logic g;
  logic g_fall;
  logic g_rise;
  logic running;
  logic inc;
  logic hit;
  logic cmp_mode;
  logic clr;
  logic wr_a;
  logic stop_hi;
  logic [17:0] nxt;

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    n = r;
    // pins pass two flops, third flop gives the edge reference
    n.s1 = {low_freq_clock_i, partner_timer_output_i, external_gate_input_i,
            external_count_input_i};
    n.s2 = r.s1;
    n.s3 = r.s2;
    // free-running dividers of high and low clock
    n.hdiv = r.hdiv + 23'h000001;
    fs_edge = r.s2[3] & ~r.s3[3];
    if (fs_edge)
    begin
      n.fdiv = r.fdiv + 15'h0001;
    end
    fs_src = r.low_speed | r.div_stage;
    // internal count tick
    unique case (r.clksel)
      mtc_pkg::MTC_C23: itick = fs_src ? (fs_edge & (&r.fdiv[14:0])) : (&r.hdiv[22:0]);
      mtc_pkg::MTC_C13: itick = fs_src ? (fs_edge & (&r.fdiv[4:0])) : (&r.hdiv[12:0]);
      mtc_pkg::MTC_C11: itick = fs_src ? (fs_edge & (&r.fdiv[2:0])) : (&r.hdiv[10:0]);
      mtc_pkg::MTC_C7: itick = &r.hdiv[6:0];
      mtc_pkg::MTC_C3: itick = &r.hdiv[2:0];
      mtc_pkg::MTC_CFC: itick = 1'b1;
      mtc_pkg::MTC_CFS: itick = fs_edge;
      mtc_pkg::MTC_CEXT: itick = 1'b0;
    endcase
    // internal gate period tick, synchronous to the divider
    unique case (r.gclk)
      2'b00: gtick = fs_src ? (fs_edge & (&r.fdiv[3:0])) : (&r.hdiv[11:0]);
      2'b01: gtick = fs_src ? (fs_edge & (&r.fdiv[4:0])) : (&r.hdiv[12:0]);
      2'b10: gtick = fs_src ? (fs_edge & (&r.fdiv[5:0])) : (&r.hdiv[13:0]);
      2'b11: gtick = 1'b0;
    endcase
    e = r.s2[0];
    e_fall = r.s3[0] & ~r.s2[0];
    e_rise = ~r.s3[0] & r.s2[0];
    // window gate source
    unique case (r.gsrc)
      mtc_pkg::MTC_G_PIN: g = r.s2[1];
      mtc_pkg::MTC_G_INT: g = r.g_on;
      mtc_pkg::MTC_G_PART: g = r.s2[2];
      mtc_pkg::MTC_G_RSV: g = 1'b0;
    endcase
    n.gate_d = g;
    g_fall = r.gate_d & ~g;
    g_rise = ~r.gate_d & g;
    running = r.run != `MTC_RUN_STOP;
    wr_a = we_i & (addr_i == `MTC_OFS_CTRL_A);
    clr = wr_a & wdata_i[`MTC_CA_CLEAR];
    stop_hi = wr_a & (wdata_i[`MTC_CA_RUN] == `MTC_RUN_STOP) & running
              & (r.mode == mtc_pkg::MTC_PULSE) & e;
    // count and interrupt causes per mode
    inc = 1'b0;
    n.irq = 1'b0;
    cmp_mode = 1'b0;
    unique case (r.mode)
      mtc_pkg::MTC_TIMER:
      begin
        inc = running & itick;
        cmp_mode = 1'b1;
      end
      mtc_pkg::MTC_EVENT:
      begin
        inc = running & e_fall & (r.clksel == mtc_pkg::MTC_CEXT);
        cmp_mode = 1'b1;
      end
      mtc_pkg::MTC_PULSE:
      begin
        inc = running & itick & e;
        n.irq = running & (e_fall | (r.gedge & e_rise));
      end
      mtc_pkg::MTC_FREQ:
      begin
        // single edge counts falls of pin AND gate; a gate fall with pin high adds one
        if (r.edge_both)
        begin
          inc = g & (e_fall | e_rise) | g_fall;
        end
        else
        begin
          inc = (r.s3[0] & r.gate_d) & ~(e & g);
        end
        inc = inc & running & (r.clksel == mtc_pkg::MTC_CEXT);
        n.irq = running & (g_fall | (r.gedge & g_rise));
      end
    endcase
    n.irq = n.irq | stop_hi;
    // compare, with the low bits ignored for the high clock in low-speed mode
    nxt = r.cnt + 18'h00001;
    if (r.low_speed & (r.clksel == mtc_pkg::MTC_CFC))
    begin
      hit = cmp_mode & (nxt[`MTC_CNT_MSB:`MTC_CMP_HI_LSB]
                        == r.cmp[`MTC_CNT_MSB:`MTC_CMP_HI_LSB]);
    end
    else
    begin
      hit = cmp_mode & (nxt == r.cmp);
    end
    // counter, overflow; the clear command wins for the count, a wrap wins for the flag
    if (clr)
    begin
      n.ovf = 1'b0;
    end
    if (inc & hit)
    begin
      n.cnt = `MTC_CNT_ZERO;
      n.irq = 1'b1;
    end
    else if (inc)
    begin
      n.cnt = nxt;
      if (r.cnt == `MTC_CNT_MAX)
      begin
        n.ovf = 1'b1;
      end
    end
    if (clr)
    begin
      n.cnt = `MTC_CNT_ZERO;
    end
    // internal window gate generator
    if (!running)
    begin
      n.g_act = 1'b0;
      n.g_on = 1'b0;
    end
    else if (gtick)
    begin
      if (!r.g_act)
      begin
        n.g_act = 1'b1;
        n.g_on = 1'b1;
        n.g_ta = r.gset[`MTC_GS_HIGH];
        n.g_tb = r.gset[`MTC_GS_LOW];
        n.g_cnt = r.gset[`MTC_GS_HIGH];
      end
      else if (r.g_cnt == `MTC_GCNT_LAST)
      begin
        if (r.g_on)
        begin
          // setting latched at each low period start
          n.g_on = 1'b0;
          n.g_ta = r.gset[`MTC_GS_HIGH];
          n.g_tb = r.gset[`MTC_GS_LOW];
          n.g_cnt = r.gset[`MTC_GS_LOW];
        end
        else
        begin
          n.g_on = 1'b1;
          n.g_cnt = r.g_ta;
        end
      end
      else
      begin
        n.g_cnt = r.g_cnt + 4'h1;
      end
    end
    // partner output reaches its pin only when not disabled
    n.pin = r.s2[2] & ~r.pdis;
    // register writes
    if (wr_a)
    begin
      n.run = wdata_i[`MTC_CA_RUN];
      n.mode = mtc_pkg::mtc_mode_e'(wdata_i[`MTC_CA_MODE]);
      n.clksel = mtc_pkg::mtc_clk_e'(wdata_i[`MTC_CA_CLKSEL]);
      n.low_speed = wdata_i[`MTC_CA_LOWSPEED];
      n.div_stage = wdata_i[`MTC_CA_DIVSTAGE];
    end
    if (we_i & (addr_i == `MTC_OFS_CTRL_B))
    begin
      n.edge_both = wdata_i[`MTC_CB_EDGE];
      n.gsrc = mtc_pkg::mtc_gsrc_e'(wdata_i[`MTC_CB_GSRC]);
      n.gedge = wdata_i[`MTC_CB_GEDGE];
      n.gclk = wdata_i[`MTC_CB_GCLK];
      n.pdis = wdata_i[`MTC_CB_PDIS];
    end
    if (we_i & (addr_i == `MTC_OFS_COMPARE))
    begin
      n.cmp = wdata_i[`MTC_CNT_MSB:0];
    end
    if (we_i & (addr_i == `MTC_OFS_GATE_SET))
    begin
      n.gset = wdata_i[7:0];
    end
    // register reads, data stand one cycle after the strobe
    n.rdata = 32'h00000000;
    if (re_i)
    begin
      unique case (addr_i)
        `MTC_OFS_CTRL_A: n.rdata = {22'h000000, r.div_stage, r.low_speed, 1'b0,
                                    r.clksel, r.mode, r.run};
        `MTC_OFS_CTRL_B: n.rdata = {25'h0000000, r.pdis, r.gclk, r.gedge, r.gsrc,
                                    r.edge_both};
        `MTC_OFS_COMPARE: n.rdata = {14'h0000, r.cnt};
        `MTC_OFS_GATE_SET: n.rdata = {24'h000000, r.gset};
        `MTC_OFS_STATUS: n.rdata = {30'h00000000, g, r.ovf};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      r <= '0;
      r.cmp <= `MTC_CMP_RST;
      r.gset <= `MTC_GS_RST;
    end
    else
    begin
      r <= n;
    end
  end

  assign rdata_o = r.rdata;
  assign counter_one_irq_o = r.irq;
  assign partner_pin_o = r.pin;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  a_ovf_sticky_hold: assert property (r.ovf && !clr |=> r.ovf)
    else $error("overflow flag dropped without clear");
  a_ovf_wrap_set: assert property (inc && !hit && !clr && r.cnt == `MTC_CNT_MAX
    |=> r.ovf && r.cnt == `MTC_CNT_ZERO)
    else $error("wrap did not set overflow");
  a_match_clear: assert property (inc && hit && !clr |=> r.cnt == `MTC_CNT_ZERO && r.irq)
    else $error("compare match did not clear and interrupt");
  a_read_live_count: assert property (re_i && addr_i == `MTC_OFS_COMPARE
    |=> rdata_o == {14'h0000, $past(r.cnt)})
    else $error("compare read did not return the count");
  a_partner_block: assert property (r.pdis && $past(r.pdis) |-> !partner_pin_o)
    else $error("partner pin driven while disabled");
  a_pulse_gate_low: assert property (r.mode == mtc_pkg::MTC_PULSE && !e && !clr
    |=> $stable(r.cnt))
    else $error("pulse width counted with input low");
  a_event_falling: assert property (r.mode == mtc_pkg::MTC_EVENT && !e_fall && !clr
    |=> $stable(r.cnt))
    else $error("event count moved without falling edge");
  a_stop_high_irq: assert property (stop_hi |=> counter_one_irq_o)
    else $error("stop with input high gave no interrupt");
  a_freq_fall_irq: assert property (r.mode == mtc_pkg::MTC_FREQ && running && g_fall
    |=> counter_one_irq_o)
    else $error("gate fall gave no interrupt");

  // a stopped counter keeps its value for a later resume
  a_stop_keeps_count: assert property (!running && !clr |=> $stable(r.cnt))
    else $error("stopped counter changed");

  // the clear command empties the counter in the next cycle
  a_clear_count: assert property (clr |=> r.cnt == `MTC_CNT_ZERO)
    else $error("clear command left a count");

  // the clear command drops the overflow flag unless a wrap sets it again
  a_clear_ovf: assert property (clr && !(inc && !hit && r.cnt == `MTC_CNT_MAX)
    |=> !r.ovf)
    else $error("clear command kept the overflow flag");

  // a timer tick without a match adds exactly one
  a_timer_step: assert property (r.mode == mtc_pkg::MTC_TIMER && inc && !hit && !clr
    |=> r.cnt == $past(r.cnt) + 18'h00001)
    else $error("timer tick did not add one");

  // in low-speed mode on the high clock only the upper compare bits matter
  a_upper_match: assert property (r.low_speed && r.clksel == mtc_pkg::MTC_CFC && cmp_mode
    && inc && nxt[`MTC_CNT_MSB:`MTC_CMP_HI_LSB] == r.cmp[`MTC_CNT_MSB:`MTC_CMP_HI_LSB] && !clr
    |=> r.cnt == `MTC_CNT_ZERO)
    else $error("upper bit match did not clear");

  // pulse width mode interrupts on the falling edge of the window input
  a_pulse_fall_irq: assert property (r.mode == mtc_pkg::MTC_PULSE && running && e_fall
    |=> counter_one_irq_o)
    else $error("window fall gave no interrupt");

  // frequency mode holds the count while the window gate stays low
  a_freq_gate_shut: assert property (r.mode == mtc_pkg::MTC_FREQ && !g && !r.gate_d && !clr
    |=> $stable(r.cnt))
    else $error("frequency count moved with gate low");

  // the status read shows the level of the selected gate
  a_gate_flag: assert property (re_i && addr_i == `MTC_OFS_STATUS
    |=> rdata_o[`MTC_ST_GATE] == $past(g))
    else $error("gate flag differs from gate level");

  // with the disable bit clear the partner output reaches its pin a cycle later
  a_partner_pass: assert property (!r.pdis |=> partner_pin_o == $past(r.s2[2]))
    else $error("partner output did not reach its pin");

  // the internal gate opens on the first gate tick after the start
  a_gate_first_open: assert property (running && gtick && !r.g_act |=> r.g_on)
    else $error("internal gate did not open on its first tick");

  // event mode match raises the interrupt and restarts from zero
  a_event_match: assert property (r.mode == mtc_pkg::MTC_EVENT && inc && hit && !clr
    |=> r.cnt == `MTC_CNT_ZERO && counter_one_irq_o)
    else $error("event match did not restart the count");

  // internal gate ends its high phase when the period count runs out
  a_gate_close: assert property (running && gtick && r.g_act && r.g_on
    && r.g_cnt == `MTC_GCNT_LAST |=> !r.g_on)
    else $error("internal gate high phase did not end");

endmodule // mtc_top

// ==== tb/mtc_far_side.sv ====
// far side model: count pin pulses, window gate pin and partner timer output
`timescale 1ns/1ps

module mtc_far_side (
  input wire logic clk_i, // system clock
  output logic count_o, // external count input pin
  output logic gate_o, // external gate pin
  output logic part_o, // partner timer output
  output logic lfclk_o // low frequency clock pin
);
  logic [1:0] lf_div = 2'h0;

  // all pins start low
  initial
  begin
    count_o = 1'b0;
    gate_o = 1'b0;
    part_o = 1'b0;
    lfclk_o = 1'b0;
  end

  // free-running low frequency clock, one period every 8 system clocks
  always @(posedge clk_i)
  begin
    lf_div <= lf_div + 2'h1;
    if (lf_div == 2'h3)
      lfclk_o <= ~lfclk_o;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pulse train of 8 high and 9 low cycles, a seventeenth of the clock
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_i) count_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      count_o <= 1'b0;
      repeat (8) @(posedge clk_i);
    end
  endtask

  // one high window of n cycles, then a low rest
  task automatic high(input int n);
    @(posedge clk_i) count_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    count_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  // set one level: 0 count pin, 1 gate pin, other partner output
  task automatic set(input int s, input logic b);
    @(posedge clk_i);
    case (s)
      0: count_o <= b;
      1: gate_o <= b;
      default: part_o <= b;
    endcase
  endtask
endmodule // mtc_far_side

// ==== tb/tb_mtc_top.sv ====
// self-checking testbench of the multimode timer/counter
`timescale 1ns/1ps
`include "mtc_defs.svh"

module tb_mtc_top;
  typedef struct {logic [7:0] a; logic [31:0] r; logic [31:0] w; logic [31:0] e;} mtc_row_s;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic pin;
  logic [31:0] v;
  wire logic external_count_input;
  wire logic egate;
  wire logic part;
  wire logic lfclk;
  int err_total = 0;
  int num_checks = 0;
  int nirq = 0;
  int cyc = 0;
  int t_last = 0;
  int t_prev = 0;
  int k;
  int n;
  // address, reset value, written value, value read back
  mtc_row_s rows [6] = '{
    '{`MTC_OFS_CTRL_A, 32'h0, 32'h80, 32'h0},
    '{`MTC_OFS_CTRL_B, 32'h0, 32'h7E, 32'h7E},
    '{`MTC_OFS_COMPARE, 32'h0, 32'h1234, 32'h0},
    '{`MTC_OFS_GATE_SET, 32'h0, 32'hA5, 32'hA5},
    '{`MTC_OFS_STATUS, 32'h0, 32'h3, 32'h0},
    '{8'h20, 32'h0, 32'hFF, 32'h0}};

  mtc_top DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .we_i(we),
    .re_i(re), .rdata_o(rdata), .external_count_input_i(external_count_input), .external_gate_input_i(egate),
    .partner_timer_output_i(part), .low_freq_clock_i(lfclk), .counter_one_irq_o(irq),
    .partner_pin_o(pin));
  mtc_far_side far (.clk_i(clk_i), .count_o(external_count_input), .gate_o(egate), .part_o(part),
    .lfclk_o(lfclk));

  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 clk_i = ~clk_i;

  // irq pulse count and the cycle of the last two pulses
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (irq === 1'b1)
    begin
      nirq <= nirq + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles and comparisons
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic wait_irq(input int t);
    for (int i = 0; i < 30000 && nirq < t; i++) @(posedge clk_i);
    chk("irq wait", 32'(t), 32'(nirq));
    if (nirq < t) end_of_test();
  endtask

  // polls the gate flag until it reads b, n counts the reads
  task automatic wait_gate(input logic b);
    n = 0;
    do
    begin
      rd(`MTC_OFS_STATUS);
      n++;
    end while (v[`MTC_ST_GATE] !== b && n < 6000);
    if (n >= 6000) chk("gate wait", 32'h0, 32'h1);
    if (n >= 6000) end_of_test();
  endtask

  task automatic stop_clear();
    wr(`MTC_OFS_CTRL_A, 32'h0);
    wr(`MTC_OFS_CTRL_A, 32'h80);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (rows[i])
    begin
      rd(rows[i].a);
      chk("reset value", rows[i].r, v);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      chk("read back", rows[i].e, v);
    end
    wr(`MTC_OFS_GATE_SET, 32'h0);
    wr(`MTC_OFS_CTRL_B, 32'h0);
    $display("test registers done");
    // timer on the system clock, then low-speed with upper bits only
    wr(`MTC_OFS_COMPARE, 32'h5);
    wr(`MTC_OFS_CTRL_A, 32'h51);
    wait_irq(nirq + 2);
    chk("timer period", 32'h5, 32'(t_last - t_prev));
    wr(`MTC_OFS_CTRL_A, 32'h0);
    wr(`MTC_OFS_COMPARE, 32'h805);
    wr(`MTC_OFS_CTRL_A, 32'h151);
    wait_irq(nirq + 2);
    chk("upper match period", 32'h800, 32'(t_last - t_prev));
    // low frequency clock straight, then through its divider tap
    stop_clear();
    wr(`MTC_OFS_COMPARE, 32'h3);
    wr(`MTC_OFS_CTRL_A, 32'h61);
    wait_irq(nirq + 2);
    chk("low clock period", 32'd24, 32'(t_last - t_prev));
    stop_clear();
    wr(`MTC_OFS_COMPARE, 32'h2);
    wr(`MTC_OFS_CTRL_A, 32'h221);
    wait_irq(nirq + 2);
    chk("divided low clock period", 32'd128, 32'(t_last - t_prev));
    $display("test timer done");
    // event counter
    stop_clear();
    wr(`MTC_OFS_COMPARE, 32'h3);
    wr(`MTC_OFS_CTRL_A, 32'h75);
    k = nirq;
    far.pulses(3);
    chk("event irq", 32'(k + 1), 32'(nirq));
    far.pulses(2);
    rd(`MTC_OFS_COMPARE);
    chk("event count", 32'h2, v);
    $display("test event done");
    // pulse width: measure, resume, both edges, stop while high
    stop_clear();
    wr(`MTC_OFS_COMPARE, 32'h3FFFF);
    wr(`MTC_OFS_CTRL_A, 32'h59);
    k = nirq;
    far.high(20);
    chk("width irq", 32'(k + 1), 32'(nirq));
    wr(`MTC_OFS_CTRL_A, 32'h0);
    rd(`MTC_OFS_COMPARE);
    chk("width", 32'd20, v);
    wr(`MTC_OFS_CTRL_A, 32'h59);
    far.high(10);
    wr(`MTC_OFS_CTRL_A, 32'h0);
    rd(`MTC_OFS_COMPARE);
    chk("width resumed", 32'd30, v);
    wr(`MTC_OFS_CTRL_B, 32'h08);
    wr(`MTC_OFS_CTRL_A, 32'h59);
    k = nirq;
    far.high(20);
    chk("both edge irq", 32'(k + 2), 32'(nirq));
    wr(`MTC_OFS_CTRL_A, 32'h0);
    wr(`MTC_OFS_CTRL_B, 32'h0);
    wr(`MTC_OFS_CTRL_A, 32'h59);
    far.set(0, 1'b1);
    repeat (5) @(posedge clk_i);
    k = nirq;
    wr(`MTC_OFS_CTRL_A, 32'h0);
    repeat (4) @(posedge clk_i);
    chk("stop irq", 32'(k + 1), 32'(nirq));
    far.set(0, 1'b0);
    $display("test pulse width done");
    // frequency with the gate pin
    stop_clear();
    wr(`MTC_OFS_CTRL_A, 32'h7D);
    k = nirq;
    far.set(1, 1'b1);
    far.pulses(4);
    rd(`MTC_OFS_STATUS);
    chk("gate flag", 32'h2, v & 32'h2);
    far.set(1, 1'b0);
    repeat (5) @(posedge clk_i);
    chk("gate fall irq", 32'(k + 1), 32'(nirq));
    far.pulses(2);
    rd(`MTC_OFS_COMPARE);
    chk("freq count", 32'h4, v);
    // both pin edges inside the gate, plus one at the gate fall
    stop_clear();
    wr(`MTC_OFS_CTRL_B, 32'h01);
    wr(`MTC_OFS_CTRL_A, 32'h7D);
    far.set(1, 1'b1);
    far.pulses(2);
    far.set(1, 1'b0);
    repeat (5) @(posedge clk_i);
    rd(`MTC_OFS_COMPARE);
    chk("freq both edges", 32'h5, v);
    // internal gate, 4096 cycles high and low
    wr(`MTC_OFS_CTRL_A, 32'h0);
    wr(`MTC_OFS_GATE_SET, 32'hFF);
    wr(`MTC_OFS_CTRL_B, 32'h02);
    wr(`MTC_OFS_CTRL_A, 32'h7D);
    wait_gate(1'b1);
    wait_gate(1'b0);
    chk("gate high reads", 32'h1, 32'(n > 2045 && n < 2051));
    wait_gate(1'b1);
    chk("gate low reads", 32'h1, 32'(n > 2045 && n < 2051));
    $display("test frequency done");
    // partner output as gate and its pin
    wr(`MTC_OFS_CTRL_A, 32'h0);
    wr(`MTC_OFS_CTRL_B, 32'h04);
    far.set(2, 1'b1);
    repeat (5) @(posedge clk_i);
    chk("partner pin", 32'h1, {31'h0, pin});
    rd(`MTC_OFS_STATUS);
    chk("partner gate", 32'h2, v & 32'h2);
    wr(`MTC_OFS_CTRL_B, 32'h44);
    repeat (4) @(posedge clk_i);
    chk("pin blocked", 32'h0, {31'h0, pin});
    rd(`MTC_OFS_STATUS);
    chk("gate kept", 32'h2, v & 32'h2);
    $display("test partner done");
    // reset in mid-run: registers back to reset values, partner pin driven again
    wr(`MTC_OFS_CTRL_A, 32'h59);
    nrst_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(`MTC_OFS_CTRL_B);
    chk("reset ctrl b", 32'h0, v);
    rd(`MTC_OFS_CTRL_A);
    chk("reset ctrl a", 32'h0, v);
    chk("pin after reset", 32'h1, {31'h0, pin});
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule // tb_mtc_top
